// File: hw/duc_channel.v
`include "duc_defs.vh"

module duc_channel #(
  parameter DIV_W = 16
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_b_i,
  input wire ce_i,
  // register port
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  // serial
  input wire rx_i,
  output wire tx_o,
  // modem
  input wire clear_to_send_n_i,
  input wire set_ready_n_i,
  input wire carrier_detect_n_i,
  input wire ring_indicator_n_i,
  output reg request_to_send_n_o,
  output reg terminal_ready_n_o,
  output reg general_output2_n_o,
  // interrupt
  output reg channel_irq_out_o,
  output reg channel_irq_out_oe_o
);

  localparam RX_IDLE = 3'd0;
  localparam RX_START = 3'd1;
  localparam RX_DATA = 3'd2;
  localparam RX_PAR = 3'd3;
  localparam RX_STOP = 3'd4;

  function hit;
    input [3:0] a;
    input [3:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: {ring, carrier, set, clear, rx}
  wire [4:0] pin_raw;
  reg [4:0] sync1_q;
  reg [4:0] sync2_q;
  assign pin_raw = {ring_indicator_n_i, carrier_detect_n_i, set_ready_n_i,
                    clear_to_send_n_i, rx_i};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_sync
      always @(posedge mclk_i)
      begin
        if (!rst_b_i)
        begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
        end
        else if (ce_i)
        begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // registers of this channel
  reg [7:0] ien_q;
  reg [7:0] lctl_q;
  reg [7:0] mctl_q;
  reg [7:0] efeat_q;
  reg [7:0] mode_q;
  reg [DIV_W-1:0] div_q;
  reg [`DUC_ST_W-1:0] stat_q;
  reg [`DUC_ST_W-1:0] stat_d;
  reg [7:0] thr_q;
  reg thr_full_q;
  reg [7:0] rbuf_q;
  reg rrdy_q;
  reg [3:0] modem_prev_q;

  wire wr_data = wr_i && hit(addr_i, `DUC_A_DATA);
  wire rd_data = rd_i && hit(addr_i, `DUC_A_DATA);
  wire x4 = mode_q[`DUC_MD_X4];
  wire ir = mctl_q[`DUC_MC_IR];
  wire [3:0] last_ph = x4 ? `DUC_OS4_LAST : `DUC_OS16_LAST;
  wire [3:0] mid_ph = x4 ? `DUC_OS4_MID : `DUC_OS16_MID;

  // event wires from the serial paths and the modem pins
  reg ev_rx;
  reg ev_perr;
  reg ev_ferr;
  reg ev_ovr;
  wire tx_busy;
  wire tx_done;
  wire [`DUC_ST_W-1:0] ev;
  wire modem_chg = |(modem_prev_q ^ sync2_q[4:1]);
  assign ev = {ev_ovr, modem_chg, ev_ferr, ev_perr, tx_done, ev_rx};

  always @*
  begin
    stat_d = stat_q;
    if (wr_i && hit(addr_i, `DUC_A_ISTAT))
      stat_d = stat_d & ~wdata_i[`DUC_ST_W-1:0];
    stat_d = stat_d | ev;
  end

  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      ien_q <= `DUC_RST_REG;
      lctl_q <= `DUC_RST_LCTL;
      mctl_q <= `DUC_RST_REG;
      efeat_q <= `DUC_RST_REG;
      mode_q <= `DUC_RST_REG;
      div_q <= `DUC_RST_DIV;
      stat_q <= {`DUC_ST_W{1'b0}};
      modem_prev_q <= 4'hf;
    end
    else if (ce_i)
    begin
      stat_q <= stat_d;
      modem_prev_q <= sync2_q[4:1];
      if (wr_i)
      begin
        case (addr_i)
          `DUC_A_IEN: ien_q <= wdata_i;
          `DUC_A_LCTL: lctl_q <= wdata_i;
          `DUC_A_MCTL: mctl_q <= wdata_i;
          `DUC_A_DIVL: div_q[7:0] <= wdata_i;
          `DUC_A_DIVH: div_q[DIV_W-1:8] <= wdata_i[DIV_W-9:0];
          `DUC_A_EFEAT: efeat_q <= wdata_i;
          `DUC_A_MODE: mode_q <= wdata_i;
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // baud generator: prescaler then divisor, one tick per sample phase
  reg [1:0] pre_q;
  reg [DIV_W-1:0] bcnt_q;
  reg tick_q;
  wire pre_ok = !mctl_q[`DUC_MC_PRE4] || (pre_q == 2'h3);
  wire [DIV_W:0] bcnt_inc = {1'b0, bcnt_q} + {{DIV_W{1'b0}}, 1'b1};

  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      pre_q <= 2'h0;
      bcnt_q <= {DIV_W{1'b0}};
      tick_q <= 1'b0;
    end
    else if (ce_i)
    begin
      pre_q <= pre_q + 2'h1;
      tick_q <= 1'b0;
      if (pre_ok)
      begin
        if (bcnt_inc >= {1'b0, div_q})
        begin
          bcnt_q <= {DIV_W{1'b0}};
          tick_q <= 1'b1;
        end
        else
          bcnt_q <= bcnt_inc[DIV_W-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transmit holding and flow gate
  wire auto_clr = efeat_q[`DUC_EF_AUTOCLR] && ien_q[`DUC_IE_CLR];
  wire tx_permit = !auto_clr || !sync2_q[1];
  wire tx_load = thr_full_q && !tx_busy && tx_permit;

  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      thr_q <= 8'h00;
      thr_full_q <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_data)
      begin
        thr_q <= wdata_i;
        thr_full_q <= 1'b1;
      end
      else if (tx_load)
        thr_full_q <= 1'b0;
    end
  end

  duc_tx u_tx (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .tick_i(tick_q),
    .last_ph_i(last_ph),
    .wlen_i(lctl_q[`DUC_LC_WLEN_HI:`DUC_LC_WLEN_LO]),
    .par_en_i(lctl_q[`DUC_LC_PAREN]),
    .even_i(lctl_q[`DUC_LC_EVEN]),
    .stop2_i(lctl_q[`DUC_LC_STOP2]),
    .ir_i(ir),
    .load_i(tx_load),
    .data_i(thr_q),
    .busy_o(tx_busy),
    .done_o(tx_done),
    .tx_o(tx_o)
  );

  //////////////////////////////////////////////////////////////////////////
  // receiver with infrared pulse stretcher
  reg [3:0] ir_cnt_q;
  reg rx_prev_q;
  reg [2:0] rx_st_q;
  reg [3:0] rx_ph_q;
  reg [2:0] rx_cnt_q;
  reg [7:0] rx_sh_q;
  reg rx_par_q;
  wire rx_eff = ir ? (ir_cnt_q == 4'h0) && !sync2_q[0] : sync2_q[0];
  wire rx_even = lctl_q[`DUC_LC_EVEN];
  wire [1:0] wlen = lctl_q[`DUC_LC_WLEN_HI:`DUC_LC_WLEN_LO];
  wire rx_end = tick_q && (rx_ph_q == last_ph);

  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      ir_cnt_q <= 4'h0;
      rx_prev_q <= 1'b1;
      rx_st_q <= RX_IDLE;
      rx_ph_q <= 4'h0;
      rx_cnt_q <= 3'h0;
      rx_sh_q <= 8'h00;
      rx_par_q <= 1'b0;
      rbuf_q <= 8'h00;
      rrdy_q <= 1'b0;
      ev_rx <= 1'b0;
      ev_perr <= 1'b0;
      ev_ferr <= 1'b0;
      ev_ovr <= 1'b0;
    end
    else if (ce_i)
    begin
      ev_rx <= 1'b0;
      ev_perr <= 1'b0;
      ev_ferr <= 1'b0;
      ev_ovr <= 1'b0;
      rx_prev_q <= rx_eff;
      if (ir && sync2_q[0])
        ir_cnt_q <= last_ph;
      else if (tick_q && ir_cnt_q != 4'h0)
        ir_cnt_q <= ir_cnt_q - 4'h1;
      if (rd_data)
        rrdy_q <= 1'b0;
      if (tick_q)
        rx_ph_q <= rx_end ? 4'h0 : rx_ph_q + 4'h1;
      case (rx_st_q)
        RX_IDLE:
        begin
          if (rx_prev_q && !rx_eff)
          begin
            rx_st_q <= RX_START;
            rx_ph_q <= 4'h0;
          end
        end
        RX_START:
        begin
          if (tick_q && rx_ph_q == mid_ph)
          begin
            rx_ph_q <= 4'h0;
            rx_cnt_q <= 3'h0;
            rx_par_q <= 1'b0;
            rx_st_q <= rx_eff ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (rx_end)
          begin
            rx_sh_q <= {rx_eff, rx_sh_q[7:1]};
            rx_par_q <= rx_par_q ^ rx_eff;
            rx_cnt_q <= rx_cnt_q + 3'h1;
            if (rx_cnt_q == {1'b1, wlen})
              rx_st_q <= lctl_q[`DUC_LC_PAREN] ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR:
        begin
          if (rx_end)
          begin
            ev_perr <= ((rx_par_q ^ rx_eff) == rx_even);
            rx_st_q <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          if (rx_end)
          begin
            ev_ferr <= !rx_eff;
            ev_ovr <= rrdy_q && !rd_data;
            ev_rx <= 1'b1;
            rbuf_q <= rx_sh_q >> (2'h3 - wlen);
            rrdy_q <= 1'b1;
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read port and registered pins
  wire auto_req = efeat_q[`DUC_EF_AUTOREQ] && ien_q[`DUC_IE_REQ];

  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      rdata_o <= 8'h00;
      request_to_send_n_o <= 1'b1;
      terminal_ready_n_o <= 1'b1;
      general_output2_n_o <= 1'b1;
      channel_irq_out_o <= 1'b0;
      channel_irq_out_oe_o <= 1'b0;
    end
    else if (ce_i)
    begin
      rdata_o <= 8'h00;
      if (rd_i)
      begin
        case (addr_i)
          `DUC_A_DATA: rdata_o <= rbuf_q;
          `DUC_A_IEN: rdata_o <= ien_q;
          `DUC_A_ISTAT: rdata_o <= {2'b00, stat_q};
          `DUC_A_LCTL: rdata_o <= lctl_q;
          `DUC_A_MCTL: rdata_o <= mctl_q;
          `DUC_A_LSTAT: rdata_o <= {1'b0, !thr_full_q && !tx_busy,
                                    !thr_full_q, 4'h0, rrdy_q};
          `DUC_A_MSTAT: rdata_o <= {~sync2_q[3], ~sync2_q[4], ~sync2_q[2],
                                    ~sync2_q[1], 4'h0};
          `DUC_A_DIVL: rdata_o <= div_q[7:0];
          `DUC_A_DIVH: rdata_o <= div_q[DIV_W-1:8];
          `DUC_A_EFEAT: rdata_o <= efeat_q;
          `DUC_A_MODE: rdata_o <= mode_q;
          default: rdata_o <= 8'h00;
        endcase
      end
      // auto request drops while a received byte waits
      request_to_send_n_o <= !(mctl_q[`DUC_MC_REQ] &&
                               !(auto_req && rrdy_q));
      terminal_ready_n_o <= !mctl_q[`DUC_MC_TREADY];
      general_output2_n_o <= !mctl_q[`DUC_MC_OUT2];
      channel_irq_out_oe_o <= mctl_q[`DUC_MC_OUT2];
      channel_irq_out_o <= |(stat_q & ien_q[`DUC_ST_W-1:0]);
    end
  end

endmodule // duc_channel

// File: hw/duc_defs.vh
`ifndef DUC_DEFS_VH
`define DUC_DEFS_VH
// register offsets (word index on the 4-bit address port)
`define DUC_A_DATA 4'h0
`define DUC_A_IEN 4'h1
`define DUC_A_ISTAT 4'h2
`define DUC_A_LCTL 4'h3
`define DUC_A_MCTL 4'h4
`define DUC_A_LSTAT 4'h5
`define DUC_A_MSTAT 4'h6
`define DUC_A_DIVL 4'h7
`define DUC_A_DIVH 4'h8
`define DUC_A_EFEAT 4'h9
`define DUC_A_MODE 4'ha
// line control fields
`define DUC_LC_WLEN_LO 0
`define DUC_LC_WLEN_HI 1
`define DUC_LC_STOP2 2
`define DUC_LC_PAREN 3
`define DUC_LC_EVEN 4
// modem control fields
`define DUC_MC_TREADY 0
`define DUC_MC_REQ 1
`define DUC_MC_OUT2 3
`define DUC_MC_IR 6
`define DUC_MC_PRE4 7
// enhanced feature / interrupt enable fields
`define DUC_EF_AUTOREQ 6
`define DUC_EF_AUTOCLR 7
`define DUC_IE_REQ 6
`define DUC_IE_CLR 7
// mode fields
`define DUC_MD_X4 0
// status / mask bits
`define DUC_ST_RXRDY 0
`define DUC_ST_TXDONE 1
`define DUC_ST_PERR 2
`define DUC_ST_FERR 3
`define DUC_ST_MODEM 4
`define DUC_ST_OVR 5
`define DUC_ST_W 6
// line status fields
`define DUC_LS_RXRDY 0
`define DUC_LS_THRE 5
`define DUC_LS_TEMT 6
// reset values
`define DUC_RST_REG 8'h00
`define DUC_RST_LCTL 8'h03
`define DUC_RST_DIV 16'h0001
// oversampling phases: last phase and mid phase
`define DUC_OS16_LAST 4'hf
`define DUC_OS16_MID 4'h7
`define DUC_OS4_LAST 4'h3
`define DUC_OS4_MID 4'h1
// timing
`define DUC_CLK_NS 50
`define DUC_RST_MIN_NS 40
`define DUC_RST_CYC ((`DUC_RST_MIN_NS + `DUC_CLK_NS - 1) / `DUC_CLK_NS)
`endif

// File: hw/duc_tx.v
`include "duc_defs.vh"

module duc_tx (
  // clock
  input wire mclk_i,
  input wire rst_b_i,
  input wire ce_i,
  // control
  input wire tick_i,
  input wire [3:0] last_ph_i,
  input wire [1:0] wlen_i,
  input wire par_en_i,
  input wire even_i,
  input wire stop2_i,
  input wire ir_i,
  input wire load_i,
  input wire [7:0] data_i,
  // status and line
  output reg busy_o,
  output reg done_o,
  output reg tx_o
);

  localparam ST_IDLE = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_DATA = 3'd2;
  localparam ST_PAR = 3'd3;
  localparam ST_STOP = 3'd4;

  reg [2:0] st_q;
  reg [3:0] ph_q;
  reg [2:0] cnt_q;
  reg [7:0] sh_q;
  reg par_q;
  reg line;
  wire bit_end;

  assign bit_end = tick_i && (ph_q == last_ph_i);

  always @*
  begin
    case (st_q)
      ST_START: line = 1'b0;
      ST_DATA: line = sh_q[0];
      ST_PAR: line = par_q ^ ~even_i;
      default: line = 1'b1;
    endcase
  end

  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      st_q <= ST_IDLE;
      ph_q <= 4'h0;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      par_q <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      tx_o <= 1'b1;
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      // ir: short high pulse in first quarter of a zero bit, idle low
      tx_o <= ir_i ? (~line & (ph_q <= {2'b00, last_ph_i[3:2]})) : line;
      if (tick_i)
        ph_q <= bit_end ? 4'h0 : ph_q + 4'h1;
      case (st_q)
        ST_IDLE:
        begin
          if (load_i)
          begin
            st_q <= ST_START;
            sh_q <= data_i;
            par_q <= 1'b0;
            ph_q <= 4'h0;
            busy_o <= 1'b1;
          end
        end
        ST_START:
        begin
          if (bit_end)
          begin
            st_q <= ST_DATA;
            cnt_q <= 3'h0;
          end
        end
        ST_DATA:
        begin
          if (bit_end)
          begin
            par_q <= par_q ^ sh_q[0];
            sh_q <= {1'b0, sh_q[7:1]};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == {1'b1, wlen_i})
            begin
              cnt_q <= 3'h0;
              st_q <= par_en_i ? ST_PAR : ST_STOP;
            end
          end
        end
        ST_PAR:
        begin
          if (bit_end)
          begin
            st_q <= ST_STOP;
            cnt_q <= 3'h0;
          end
        end
        ST_STOP:
        begin
          if (bit_end)
          begin
            cnt_q <= cnt_q + 3'h1;
            if (!stop2_i || cnt_q[0])
            begin
              st_q <= ST_IDLE;
              busy_o <= 1'b0;
              done_o <= 1'b1;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule // duc_tx

// File: verif/duc_channel_sva.sv
`include "duc_defs.vh"

module duc_channel_sva (
  // clock and reset
  input wire mclk_i,
  input wire rst_b_i,
  // register port
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] rdata_o,
  // line, modem and interrupt
  input wire tx_o,
  input wire request_to_send_n_o,
  input wire terminal_ready_n_o,
  input wire general_output2_n_o,
  input wire channel_irq_out_o,
  input wire channel_irq_out_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  wire mc_w = wr_i && addr_i == `DUC_A_MCTL;
  wire ie_w = wr_i && addr_i == `DUC_A_IEN;
  reg ir_q;
  // shadow of the infrared mode bit
  always @(posedge mclk_i)
    if (!rst_b_i)
      ir_q <= 1'b0;
    else if (mc_w)
      ir_q <= wdata_i[`DUC_MC_IR];
  ////////////////////////////////////////////////////////////////////////
  chk_rst_tx_idle: assert property (disable iff (1'b0)
    !rst_b_i |=> tx_o) else $error("tx not idle in reset");
  chk_rst_outs_off: assert property (disable iff (1'b0)
    !rst_b_i |=> request_to_send_n_o && terminal_ready_n_o &&
    general_output2_n_o && !channel_irq_out_oe_o && rdata_o == 8'h00)
    else $error("outputs not at defaults in reset");
  chk_op2_irq_pair: assert property (
    general_output2_n_o != channel_irq_out_oe_o)
    else $error("output2 pin and irq enable disagree");
  chk_op2_follows: assert property (mc_w ##1 !mc_w |=>
    general_output2_n_o == !$past(wdata_i[`DUC_MC_OUT2], 2))
    else $error("output2 pin does not follow control");
  chk_dtr_follows: assert property (mc_w ##1 !mc_w |=>
    terminal_ready_n_o == !$past(wdata_i[`DUC_MC_TREADY], 2))
    else $error("terminal ready does not follow control");
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read slot");
  chk_bit_width: assert property ($fell(tx_o) && !ir_q |-> !tx_o [*4])
    else $error("low bit shorter than four clocks");
  chk_irq_masked: assert property (ie_w && wdata_i == 8'h00 ##1 !ie_w
    |=> !channel_irq_out_o) else $error("irq high with all masked");
  cover property ($fell(tx_o) && !ir_q);
  cover property (rd_i ##1 rdata_o != 8'h00);
  cover property ($rose(channel_irq_out_o));
endmodule // duc_channel_sva

bind duc_channel duc_channel_sva i_duc_channel_sva (.mclk_i, .rst_b_i,
  .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .tx_o, .request_to_send_n_o,
  .terminal_ready_n_o, .general_output2_n_o, .channel_irq_out_o,
  .channel_irq_out_oe_o);

// File: verif/duc_far_dev.sv
module duc_far_dev (
  // clock and line setup
  input wire mclk_i,
  input wire [7:0] bit_clk_i,
  input wire [3:0] nbits_i,
  input wire par_en_i,
  input wire listen_i,
  input wire cts_n_cmd_i,
  // serial
  input wire tx_i,
  output logic rx_o,
  output wire clear_to_send_n_o,
  // captured frame: stop, parity, data
  output logic [9:0] frame_o,
  output logic got_o
);
  timeunit 1ns;
  timeprecision 1ns;
  assign clear_to_send_n_o = cts_n_cmd_i;
  initial
  begin
    rx_o = 1'b1;
    got_o = 1'b0;
    frame_o = 10'h000;
  end
  // sample at bit centres after the start edge
  always
  begin : rx_frame
    logic [9:0] f;
    int i;
    @(negedge tx_i iff listen_i);
    f = 10'h000;
    repeat (bit_clk_i / 2) @(posedge mclk_i);
    for (i = 0; i < nbits_i; i++)
    begin
      repeat (bit_clk_i) @(posedge mclk_i);
      f[i] = tx_i;
    end
    if (par_en_i)
    begin
      repeat (bit_clk_i) @(posedge mclk_i);
      f[8] = tx_i;
    end
    repeat (bit_clk_i) @(posedge mclk_i);
    f[9] = tx_i;
    frame_o <= f;
    got_o <= 1'b1;
    @(posedge mclk_i);
    got_o <= 1'b0;
  end
  task automatic put(input logic b);
    rx_o <= b;
    repeat (bit_clk_i) @(posedge mclk_i);
  endtask
  // line idles high between frames
  task automatic send(input logic [7:0] d, input logic p);
    int i;
    put(1'b0);
    for (i = 0; i < nbits_i; i++)
      put(d[i]);
    if (par_en_i)
      put(p);
    put(1'b1);
  endtask
endmodule // duc_far_dev

// File: verif/dual_uart_channel_control_bench.sv
`include "duc_defs.vh"

module dual_uart_channel_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_q = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [2:0] mdm_n = 3'h7;
  logic cts_cmd = 1'b1;
  logic [7:0] bitc = 8'h10;
  logic [3:0] nb = 4'h8;
  logic pen = 1'b0;
  logic listen = 1'b1;
  logic [31:0] seed = 32'h6670b917;
  logic [9:0] exp_tx[$];
  logic [7:0] exp_rd[$];
  int fails = 0;
  int check_count = 0;
  wire [7:0] rdata_o;
  wire [9:0] frame;
  wire tx_o, rx, cts_n, got, request_to_send_n_o, terminal_ready_n_o;
  wire general_output2_n_o, channel_irq_out_o, channel_irq_out_oe_o;
  always #25 mclk_i = ~mclk_i;
  duc_channel i_duc_channel (.mclk_i, .rst_b_i, .ce_i(1'b1), .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .rx_i(rx), .tx_o,
    .clear_to_send_n_i(cts_n), .set_ready_n_i(mdm_n[0]),
    .ring_indicator_n_i(mdm_n[1]), .carrier_detect_n_i(mdm_n[2]),
    .request_to_send_n_o, .terminal_ready_n_o, .general_output2_n_o,
    .channel_irq_out_o, .channel_irq_out_oe_o);
  duc_far_dev i_duc_far_dev (.mclk_i, .bit_clk_i(bitc), .nbits_i(nb),
    .par_en_i(pen), .listen_i(listen), .cts_n_cmd_i(cts_cmd), .tx_i(tx_o),
    .rx_o(rx), .clear_to_send_n_o(cts_n), .frame_o(frame), .got_o(got));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [9:0] frm(input logic [7:0] d,
    input logic [1:0] wl, input logic pe, input logic ev);
    logic [7:0] m;
    m = d & (8'hff >> (2'h3 - wl));
    return {1'b1, pe & (^m ^ !ev), m};
  endfunction
  task automatic check(input string what, input logic [9:0] exp,
    input logic [9:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic wait_tx();
    int k;
    for (k = 0; k < 3000 && exp_tx.size() != 0; k++)
      @(posedge mclk_i);
    check("frames left", 10'h000, exp_tx.size());
    cyc(150);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // results arrive here and are matched against the oldest note
  always @(posedge mclk_i)
  begin
    rd_q <= rd_i;
    if (rd_q)
      check("rdata", exp_rd.pop_front(), rdata_o);
    if (got)
      check("frame", exp_tx.pop_front(), frame);
  end
  initial
  begin
    cyc(40000);
    fails++;
    results();
  end
  initial
  begin
    int k;
    logic [7:0] d;
    cyc(3);
    rst_b_i <= 1'b1;
    for (k = 1; k < 16; k++)
      rd(k[3:0], k == 3 ? 8'h03 : k == 7 ? 8'h01 : k == 5 ? 8'h60 : 8'h00);
    $display("test registers done");
    wr(`DUC_A_MCTL, 8'h0b);
    cyc(2);
    check("modem out", 10'h001, {terminal_ready_n_o, request_to_send_n_o,
      general_output2_n_o, channel_irq_out_oe_o});
    wr(`DUC_A_MCTL, 8'h00);
    cyc(2);
    check("modem out", 10'h00e, {terminal_ready_n_o, request_to_send_n_o,
      general_output2_n_o, channel_irq_out_oe_o});
    d = xs();
    mdm_n <= d[2:0];
    cts_cmd <= d[3];
    cyc(6);
    rd(`DUC_A_MSTAT, {~d[2], ~d[1], ~d[0], ~d[3], 4'h0});
    $display("test modem done");
    for (k = 0; k < 16; k++)
    begin
      d = xs();
      bitc <= k == 14 ? 8'h40 : k == 15 ? 8'h04 : 8'h10;
      nb <= 4'h5 + k[1:0];
      pen <= k[3];
      wr(`DUC_A_MCTL, k == 14 ? 8'h80 : 8'h00);
      wr(`DUC_A_MODE, k == 15 ? 8'h01 : 8'h00);
      wr(`DUC_A_LCTL, {3'h0, d[7], k[3:0]});
      exp_tx.push_back(frm(d, k[1:0], k[3], d[7]));
      wr(`DUC_A_DATA, d);
      wait_tx();
    end
    $display("test transmit done");
    mdm_n <= 3'h7;
    cts_cmd <= 1'b1;
    wr(`DUC_A_LCTL, 8'h0b);
    cyc(6);
    wr(`DUC_A_ISTAT, 8'hff);
    wr(`DUC_A_IEN, 8'h05);
    for (k = 0; k < 5; k++)
    begin
      d = xs();
      bitc <= k[1] ? 8'h04 : 8'h10;
      wr(`DUC_A_MODE, {7'h0, k[1]});
      i_duc_far_dev.send(d, ~^d ^ k[0]);
      cyc(20);
      check("irq", 10'h001, channel_irq_out_o);
      rd(`DUC_A_ISTAT, {5'h0, k[0], 2'h1});
      if (k == 4)
      begin
        wr(`DUC_A_IEN, 8'h00);
        // irq pin is registered one cycle after the mask lands
        cyc(1);
        check("irq masked", 10'h000, channel_irq_out_o);
      end
      rd(`DUC_A_DATA, d);
      wr(`DUC_A_ISTAT, 8'hff);
      rd(`DUC_A_ISTAT, 8'h00);
    end
    $display("test receive done");
    bitc <= 8'h10;
    wr(`DUC_A_MODE, 8'h00);
    wr(`DUC_A_MCTL, 8'h02);
    wr(`DUC_A_EFEAT, 8'hc0);
    wr(`DUC_A_IEN, 8'hc0);
    exp_tx.push_back(frm(8'ha5, 2'h3, 1'b1, 1'b0));
    wr(`DUC_A_DATA, 8'ha5);
    cyc(400);
    check("tx gated", 10'h001, exp_tx.size());
    cts_cmd <= 1'b0;
    wait_tx();
    check("rts on", 10'h000, request_to_send_n_o);
    i_duc_far_dev.send(8'h3c, 1'b1);
    cyc(4);
    check("rts auto off", 10'h001, request_to_send_n_o);
    rd(`DUC_A_DATA, 8'h3c);
    cyc(3);
    check("rts back", 10'h000, request_to_send_n_o);
    $display("test flow control done");
    listen <= 1'b0;
    wr(`DUC_A_MCTL, 8'h40);
    cyc(2);
    check("ir idle", 10'h000, tx_o);
    wr(`DUC_A_MCTL, 8'h00);
    cyc(2);
    check("std idle", 10'h001, tx_o);
    wr(`DUC_A_DATA, 8'h00);
    cyc(40);
    rst_b_i <= 1'b0;
    cyc(3);
    rst_b_i <= 1'b1;
    cyc(1);
    check("tx after reset", 10'h001, tx_o);
    rd(`DUC_A_LCTL, 8'h03);
    $display("test infrared and reset done");
    results();
  end
endmodule // dual_uart_channel_control_bench
